// ===== rtl/pt_pkg.sv
// Shared constants and types of the paired 16/32-bit timer block.
`default_nettype none

package pt_pkg;

   // ************************************************************
   // Register map, byte addresses of 32-bit words.
   // ************************************************************
   localparam logic [7:0] OFS_LO_CTL   = 8'h00;
   localparam logic [7:0] OFS_HI_CTL   = 8'h04;
   localparam logic [7:0] OFS_CNT_LO   = 8'h08;
   localparam logic [7:0] OFS_CNT_HI   = 8'h0c;
   localparam logic [7:0] OFS_PER_LO   = 8'h10;
   localparam logic [7:0] OFS_PER_HI   = 8'h14;
   localparam logic [7:0] OFS_HOLD     = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1c;
   localparam logic [7:0] OFS_IRQ_EN   = 8'h20;
   localparam logic [7:0] OFS_IRQ_CLR  = 8'h24;

   // ************************************************************
   // Control register fields.
   // ************************************************************
   localparam int BIT_ON   = 15;
   localparam int BIT_IDLE = 13;
   localparam int BIT_GATE = 6;
   localparam int BIT_PS_H = 5;
   localparam int BIT_PS_L = 4;
   localparam int BIT_PAIR = 3;
   localparam int BIT_CS   = 1;

   localparam logic [15:0] LO_CTL_MASK = 16'ha07a;
   localparam logic [15:0] HI_CTL_MASK = 16'ha072;

   // ************************************************************
   // Reset values.
   // ************************************************************
   localparam logic [15:0] CTL_RESET = 16'h0000;
   localparam logic [15:0] CNT_RESET = 16'h0000;
   localparam logic [15:0] PER_RESET = 16'hffff;
   localparam logic [1:0]  IRQ_RESET = 2'h0;

   // ************************************************************
   // Interrupt bits and prescaler encodings.
   // ************************************************************
   localparam int IRQ_LO = 0;
   localparam int IRQ_HI = 1;

   typedef enum logic [1:0] {
      PS_1   = 2'b00,
      PS_8   = 2'b01,
      PS_64  = 2'b10,
      PS_256 = 2'b11
   } pt_ps_e;

   localparam logic [7:0] TERM_1   = 8'h00;
   localparam logic [7:0] TERM_8   = 8'h07;
   localparam logic [7:0] TERM_64  = 8'h3f;
   localparam logic [7:0] TERM_256 = 8'hff;

   typedef logic [15:0] pt_word_t;

endpackage : pt_pkg

`default_nettype wire

// ===== rtl/pt_if.sv
// Interfaces between the timer top and its prescaler and interrupt modules.
`default_nettype none

interface pt_presc_if;
   logic       run;
   logic       cs;
   logic       gate_en;
   logic       clr;
   logic [1:0] ps;
   logic       ext_pin;
   logic       gate_pin;
   logic       tick;
   modport ctl   (output run, cs, gate_en, clr, ps, ext_pin, gate_pin, input tick);
   modport presc (input run, cs, gate_en, clr, ps, ext_pin, gate_pin, output tick);
endinterface : pt_presc_if

interface pt_irq_if;
   logic [1:0] set;
   logic [1:0] clr;
   logic       en_we;
   logic [1:0] en_d;
   logic [1:0] status;
   logic [1:0] enable;
   logic       irq;
   modport ctl (output set, clr, en_we, en_d, input status, enable, irq);
   modport irq_side (input set, clr, en_we, en_d, output status, enable, irq);
endinterface : pt_irq_if

`default_nettype wire

// ===== rtl/pt_presc.sv
// Count-source selection, gating and prescaler of one timer lane.
`default_nettype none

module pt_presc (
   // Lane control and tick.
   pt_presc_if.presc p,
   // Clock and reset.
   input wire logic  clk,
   input wire logic  rst_b
);
   import pt_pkg::*;

   logic       ext_prev_reg;
   logic [7:0] div_reg;
   logic [7:0] term;
   logic       src_pulse;

   always_comb begin
      unique case (pt_ps_e'(p.ps))
         PS_1:   term = TERM_1;
         PS_8:   term = TERM_8;
         PS_64:  term = TERM_64;
         PS_256: term = TERM_256;
      endcase
   end

   // The external input is counted on its rising edge, sampled on clk.
   assign src_pulse = p.run & (p.cs ? (p.ext_pin & ~ext_prev_reg)
                                    : (~p.gate_en | p.gate_pin));
   assign p.tick = src_pulse & ~p.clr & (div_reg == term);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_prev_reg <= 1'b0;
      end else begin
         ext_prev_reg <= p.ext_pin;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_reg <= 8'h00;
      end else if (p.clr || !p.run) begin
         div_reg <= 8'h00;
      end else if (src_pulse) begin
         div_reg <= (div_reg == term) ? 8'h00 : 8'(div_reg + 8'h01);
      end
   end

   a_stop_no_tick: assert property (@(posedge clk) disable iff (!rst_b)
      !p.run |-> !p.tick) else $error("tick while lane stopped");

   a_presc_clear: assert property (@(posedge clk) disable iff (!rst_b)
      p.clr |=> div_reg == 8'h00) else $error("prescaler not cleared");

endmodule : pt_presc

`default_nettype wire

// ===== rtl/pt_irq.sv
// Sticky interrupt status, enable mask and level interrupt output.
`default_nettype none

module pt_irq (
   // Events, clears and status.
   pt_irq_if.irq_side q,
   // Clock and reset.
   input wire logic   clk,
   input wire logic   rst_b
);
   import pt_pkg::*;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q.status <= IRQ_RESET;
      end else begin
         // A new event beats a clear in the same cycle.
         q.status <= (q.status & ~q.clr) | q.set;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         q.enable <= IRQ_RESET;
      end else if (q.en_we) begin
         q.enable <= q.en_d;
      end
   end

   assign q.irq = |(q.status & q.enable);

   a_set_wins: assert property (@(posedge clk) disable iff (!rst_b)
      |q.set |=> (q.status & $past(q.set)) == $past(q.set)) else $error("event lost");

endmodule : pt_irq

`default_nettype wire

// ===== rtl/pt_timer.sv
// Paired 16/32-bit timer with a classic Wishbone register slave.
`default_nettype none

// Function
// - Pair select bit 3 of lower control joins both timers into one 32-bit timer.
// - While paired, every upper control bit is ignored.
// - Paired mode uses lower clock and gate but raises the upper interrupt flag.
// - Upper period is the high word, lower period the low word.
// - Upper count holds the high word, lower count the low word.
// - Count equal to period raises a period-match event.
// - Only the first pair drives the ADC trigger, from the upper match.
// - On bit starts or stops the timer; lower bit governs the pair when joined.
// - Idle-stop bit suspends counting while the system is idle.
// - With internal clock and gate enabled, count only while gate is high.
// - Prescale field selects 1:1, 1:8, 1:64 or 1:256.
// - Clock-source bit selects external rising edges or the internal clock.
// - Writing control while running clears the prescaler; software should avoid it.
// - Split timers support all 16-bit modes except asynchronous counting.
// - Joined pair is a 32-bit timer or synchronous 32-bit counter.
// - Unimplemented control bits read zero; all control bits reset to zero.
module pt_timer #(
   parameter bit FIRST_PAIR = 1'b1
) (
   // Clock and reset.
   input  wire logic        clk,
   input  wire logic        rst_b,
   // Wishbone register slave.
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // Timer pins.
   input  wire logic        external_clock_pin_lo,
   input  wire logic        external_clock_pin_hi,
   input  wire logic        gate_pin_lo,
   input  wire logic        gate_pin_hi,
   input  wire logic        idle_mode,
   // Events.
   output logic             irq,
   output logic             adc_trigger
);
   import pt_pkg::*;

   // ************************************************************
   // Registers and nets.
   // ************************************************************
   pt_word_t    lower_timer_control_reg;
   pt_word_t    upper_timer_control_reg;
   pt_word_t    count_low_word_reg;
   pt_word_t    count_high_word_reg;
   pt_word_t    period_low_word_reg;
   pt_word_t    period_high_word_reg;
   pt_word_t    high_word_hold_reg;
   logic        ack_reg;
   logic [31:0] dat_reg;
   logic [31:0] dat_next;
   logic        adc_reg;
   logic        wr_now;
   logic        rd_now;
   logic        pair_select;
   logic        tick_lo;
   logic        tick_hi;
   logic        match_lo;
   logic        match_hi;
   logic        match32;
   logic        ev_lo;
   logic        ev_hi;

   pt_presc_if pl ();
   pt_presc_if ph ();
   pt_irq_if   iq ();

   // ************************************************************
   // Bus slave helpers.
   // ************************************************************
   function automatic pt_word_t merge(input pt_word_t old_v);
      merge[15:8] = wb_sel_i[1] ? wb_dat_i[15:8] : old_v[15:8];
      merge[7:0]  = wb_sel_i[0] ? wb_dat_i[7:0]  : old_v[7:0];
   endfunction : merge

   function automatic logic wr_hit(input logic [7:0] ofs);
      wr_hit = wr_now && (wb_adr_i == ofs);
   endfunction : wr_hit

   // A request is answered one cycle after it appears. A write lands on the
   // edge where the master sees ack; a read is taken one edge earlier, when
   // its data is registered, so the high word hold matches the low word read.
   assign wr_now = ack_reg & wb_cyc_i & wb_stb_i & wb_we_i;
   assign rd_now = ~ack_reg & wb_cyc_i & wb_stb_i & ~wb_we_i;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
      end
   end

   always_comb begin
      dat_next = 32'h0000_0000;
      unique case (wb_adr_i)
         OFS_LO_CTL:   dat_next[15:0] = lower_timer_control_reg & LO_CTL_MASK;
         OFS_HI_CTL:   dat_next[15:0] = upper_timer_control_reg & HI_CTL_MASK;
         OFS_CNT_LO:   dat_next[15:0] = count_low_word_reg;
         OFS_CNT_HI:   dat_next[15:0] = count_high_word_reg;
         OFS_PER_LO:   dat_next[15:0] = period_low_word_reg;
         OFS_PER_HI:   dat_next[15:0] = period_high_word_reg;
         OFS_HOLD:     dat_next[15:0] = high_word_hold_reg;
         OFS_IRQ_STAT: dat_next[1:0]  = iq.status;
         OFS_IRQ_EN:   dat_next[1:0]  = iq.enable;
         default:      dat_next       = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dat_reg <= 32'h0000_0000;
      end else if (wb_cyc_i && wb_stb_i && !ack_reg) begin
         dat_reg <= dat_next;
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;

   // ************************************************************
   // Control and period registers.
   // ************************************************************
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         lower_timer_control_reg <= CTL_RESET;
      end else if (wr_hit(OFS_LO_CTL)) begin
         lower_timer_control_reg <= merge(lower_timer_control_reg) & LO_CTL_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         upper_timer_control_reg <= CTL_RESET;
      end else if (wr_hit(OFS_HI_CTL)) begin
         upper_timer_control_reg <= merge(upper_timer_control_reg) & HI_CTL_MASK;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         period_low_word_reg  <= PER_RESET;
         period_high_word_reg <= PER_RESET;
      end else begin
         if (wr_hit(OFS_PER_LO)) begin
            period_low_word_reg <= merge(period_low_word_reg);
         end
         if (wr_hit(OFS_PER_HI)) begin
            period_high_word_reg <= merge(period_high_word_reg);
         end
      end
   end

   // ************************************************************
   // Lane configuration.
   // ************************************************************
   assign pair_select = lower_timer_control_reg[BIT_PAIR];

   // Both lanes count synchronously to clk; there is no asynchronous
   // counter path, so an external clock must be no faster than clk / 2.
   assign pl.run = lower_timer_control_reg[BIT_ON]
                   & ~(lower_timer_control_reg[BIT_IDLE] & idle_mode);
   assign pl.cs       = lower_timer_control_reg[BIT_CS];
   assign pl.gate_en  = lower_timer_control_reg[BIT_GATE];
   assign pl.ps       = lower_timer_control_reg[BIT_PS_H:BIT_PS_L];
   assign pl.ext_pin  = external_clock_pin_lo;
   assign pl.gate_pin = gate_pin_lo;
   assign pl.clr      = wr_hit(OFS_LO_CTL) & lower_timer_control_reg[BIT_ON];

   // The upper lane is held still while paired, whatever its own bits say.
   assign ph.run = ~pair_select & upper_timer_control_reg[BIT_ON]
                   & ~(upper_timer_control_reg[BIT_IDLE] & idle_mode);
   assign ph.cs       = upper_timer_control_reg[BIT_CS];
   assign ph.gate_en  = upper_timer_control_reg[BIT_GATE];
   assign ph.ps       = upper_timer_control_reg[BIT_PS_H:BIT_PS_L];
   assign ph.ext_pin  = external_clock_pin_hi;
   assign ph.gate_pin = gate_pin_hi;
   assign ph.clr      = wr_hit(OFS_HI_CTL) & upper_timer_control_reg[BIT_ON];

   pt_presc u_presc_lo (
      .p     (pl),
      .clk   (clk),
      .rst_b (rst_b)
   );

   pt_presc u_presc_hi (
      .p     (ph),
      .clk   (clk),
      .rst_b (rst_b)
   );

   // ************************************************************
   // Counters and period match.
   // ************************************************************
   assign tick_lo  = pl.tick;
   assign tick_hi  = pair_select ? pl.tick : ph.tick;
   assign match_lo = count_low_word_reg == period_low_word_reg;
   assign match_hi = count_high_word_reg == period_high_word_reg;
   assign match32  = match_hi & match_lo;

   assign ev_lo = ~pair_select & tick_lo & match_lo;
   assign ev_hi = tick_hi & match_hi & (~pair_select | match_lo);

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_low_word_reg <= CNT_RESET;
      end else if (wr_hit(OFS_CNT_LO)) begin
         count_low_word_reg <= merge(count_low_word_reg);
      end else if (tick_lo) begin
         count_low_word_reg <= (pair_select ? match32 : match_lo) ? CNT_RESET
                               : 16'(count_low_word_reg + 16'h0001);
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         count_high_word_reg <= CNT_RESET;
      end else if (wr_hit(OFS_CNT_HI)) begin
         count_high_word_reg <= merge(count_high_word_reg);
      end else if (tick_hi) begin
         if (match_hi && (!pair_select || match_lo)) begin
            count_high_word_reg <= CNT_RESET;
         end else if (!pair_select || count_low_word_reg == 16'hffff) begin
            count_high_word_reg <= 16'(count_high_word_reg + 16'h0001);
         end
      end
   end

   // Reading the low word freezes the high word so both halves agree.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         high_word_hold_reg <= CNT_RESET;
      end else if (rd_now && wb_adr_i == OFS_CNT_LO) begin
         high_word_hold_reg <= count_high_word_reg;
      end
   end

   // ************************************************************
   // Interrupts and ADC trigger.
   // ************************************************************
   assign iq.set   = {ev_hi, ev_lo};
   assign iq.clr   = wr_hit(OFS_IRQ_CLR) ? wb_dat_i[1:0] : 2'b00;
   assign iq.en_we = wr_hit(OFS_IRQ_EN);
   assign iq.en_d  = wb_dat_i[1:0];

   pt_irq u_irq (
      .q     (iq),
      .clk   (clk),
      .rst_b (rst_b)
   );

   assign irq = iq.irq;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         adc_reg <= 1'b0;
      end else begin
         adc_reg <= FIRST_PAIR & ev_hi;
      end
   end

   assign adc_trigger = adc_reg;

   // ************************************************************
   // Checks.
   // ************************************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   sequence s_wrap32;
      pair_select && tick_lo && match32 && !wr_now;
   endsequence

   sequence s_carry32;
      pair_select && tick_lo && !match32 && count_low_word_reg == 16'hffff && !wr_now;
   endsequence

   a_ack_single: assert property (ack_reg |=> !ack_reg)
      else $error("ack held two cycles");

   a_ack_prompt: assert property (wb_cyc_i && wb_stb_i && !ack_reg |=> ack_reg)
      else $error("request not answered next cycle");

   a_ctl_unimpl_zero: assert property (
      (lower_timer_control_reg & ~LO_CTL_MASK) == 16'h0000
      && (upper_timer_control_reg & ~HI_CTL_MASK) == 16'h0000)
      else $error("unimplemented control bit set");

   a_upper_ignored: assert property (pair_select |-> !ph.tick)
      else $error("upper lane ticks while paired");

   a_lo_wrap: assert property (!pair_select && tick_lo && match_lo && !wr_now
      |=> count_low_word_reg == 16'h0000)
      else $error("16-bit count did not restart");

   a_match32_flag: assert property (s_wrap32 |=> iq.status[IRQ_HI]
      && count_low_word_reg == 16'h0000 && count_high_word_reg == 16'h0000)
      else $error("32-bit match lost");

   a_carry32: assert property (s_carry32
      |=> count_high_word_reg == 16'($past(count_high_word_reg) + 16'h0001))
      else $error("high word missed carry");

   a_stopped_hold: assert property (!lower_timer_control_reg[BIT_ON] && !wr_now
      |=> $stable(count_low_word_reg))
      else $error("stopped timer moved");

   a_adc_source: assert property (ev_hi |=> adc_trigger == FIRST_PAIR)
      else $error("ADC trigger mismatch");

   a_hold_coherent: assert property (rd_now && wb_adr_i == OFS_CNT_LO
      |=> high_word_hold_reg == $past(count_high_word_reg)
      && wb_dat_o[15:0] == $past(count_low_word_reg))
      else $error("high word hold not taken with low word");

   a_pair_flag_hi: assert property (pair_select |-> !iq.set[IRQ_LO])
      else $error("lower flag raised while paired");

   a_lo_flag16: assert property (!pair_select && tick_lo && match_lo && !wr_now
      |=> iq.status[IRQ_LO])
      else $error("16-bit match flag lost");

   a_bus_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
      else $error("read data upper half not zero");

endmodule : pt_timer

`default_nettype wire

// ===== tb/pt_pins_model.sv
// Behavioural model of the external clock and gate pins of both timer lanes.
`default_nettype none

module pt_pins_model (
   // Clock and reset.
   input  wire logic clk,
   input  wire logic rst_b,
   // Commands from the bench.
   input  wire logic run_cmd,
   input  wire logic gate_lo_cmd,
   input  wire logic gate_hi_cmd,
   // Pins.
   output var logic  ext_lo,
   output var logic  ext_hi,
   output var logic  gate_lo,
   output var logic  gate_hi
);
   timeunit 1ns;
   timeprecision 1ps;

   // The pin clock stands still between bursts and always keeps a low cycle between rises.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_lo <= 1'b0;
      end else begin
         ext_lo <= run_cmd & ~ext_lo;
      end
   end

   assign ext_hi  = ext_lo;
   assign gate_lo = gate_lo_cmd;
   assign gate_hi = gate_hi_cmd;
endmodule : pt_pins_model

`default_nettype wire

// ===== tb/test_paired_16_32_bit_timer.sv
// Self-checking bench of the paired 16/32-bit timer.
`default_nettype none

module test_paired_16_32_bit_timer import pt_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk, rst_b, cyc, stb, we, idle, run_cmd, g_lo, g_hi, adc_seen;
   logic        ext_lo, ext_hi, gate_lo, gate_hi, irq, adc, ack;
   logic [7:0]  adr;
   logic [31:0] dat, rdat;
   int          errors, samples_checked, cycles;

   pt_timer i_dut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .external_clock_pin_lo(ext_lo), .external_clock_pin_hi(ext_hi), .gate_pin_lo(gate_lo),
      .gate_pin_hi(gate_hi), .idle_mode(idle), .irq(irq), .adc_trigger(adc));
   pt_pins_model i_pins (.clk(clk), .rst_b(rst_b), .run_cmd(run_cmd), .gate_lo_cmd(g_lo),
      .gate_hi_cmd(g_hi), .ext_lo(ext_lo), .ext_hi(ext_hi), .gate_lo(gate_lo),
      .gate_hi(gate_hi));

   always #4 clk = ~clk;

   always @(posedge clk) begin
      if (adc === 1'b1) begin
         adc_seen <= 1'b1;
      end
      cycles++;
      if (cycles == 20000) begin
         errors++;
         close_out();
      end
   end

   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : close_out

   task automatic chk_val(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_val

   task automatic chk_rng(input string what, input int lo, input int hi, input logic [31:0] got);
      samples_checked++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         errors++;
         $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_rng

   // Ack and read data are sampled at a rising edge; the request is released right after it.
   task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= {16'h0000, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask : bus

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      bus(1'b0, a, 16'h0000, q);
   endtask : rd

   task automatic run_for(input logic [15:0] ctl, input int n, output logic [31:0] q);
      wr(OFS_LO_CTL, 16'h0000);
      wr(OFS_CNT_LO, 16'h0000);
      wr(OFS_LO_CTL, ctl);
      repeat (n) @(posedge clk);
      wr(OFS_LO_CTL, 16'h0000);
      rd(OFS_CNT_LO, q);
   endtask : run_for

   task automatic t_regs;
      logic [7:0]  a [6] = '{OFS_LO_CTL, OFS_HI_CTL, OFS_CNT_LO, OFS_PER_LO, OFS_IRQ_STAT, 8'h40};
      logic [15:0] e [6] = '{16'h0000, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'h0000};
      logic [31:0] q;
      for (int i = 0; i < 6; i++) begin
         rd(a[i], q);
         chk_val("reset read", {16'h0000, e[i]}, q);
      end
      wr(OFS_LO_CTL, 16'hffff);
      rd(OFS_LO_CTL, q);
      chk_val("lower control mask", 32'h0000a07a, q);
      wr(OFS_LO_CTL, 16'h0000);
      wr(OFS_HI_CTL, 16'hffff);
      rd(OFS_HI_CTL, q);
      chk_val("upper control mask", 32'h0000a072, q);
      wr(OFS_HI_CTL, 16'h0000);
      wr(OFS_IRQ_STAT, 16'h0003);
      rd(OFS_IRQ_STAT, q);
      chk_val("status write ignored", 32'h0, q);
   endtask : t_regs

   task automatic t_presc;
      int          d [4] = '{1, 8, 64, 256};
      logic [31:0] q;
      for (int i = 0; i < 4; i++) begin
         run_for(16'h8000 | 16'(i << 4), 512, q);
         chk_rng("prescaled count", (512 - 4) / d[i], (512 + 4) / d[i], q);
      end
   endtask : t_presc

   // Control writes spaced closer than the 1:8 term keep clearing the prescaler.
   task automatic t_ctl_write;
      logic [31:0] q;
      wr(OFS_CNT_LO, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         wr(OFS_LO_CTL, 16'h8010);
      end
      wr(OFS_LO_CTL, 16'h0000);
      rd(OFS_CNT_LO, q);
      chk_val("count under control writes", 32'h0, q);
   endtask : t_ctl_write

   task automatic t_source;
      logic [31:0] q;
      run_for(16'h8040, 64, q);
      chk_val("gated count", 32'h0, q);
      g_lo <= 1'b1;
      run_for(16'h8040, 64, q);
      chk_rng("gate open count", 60, 68, q);
      g_lo <= 1'b0;
      run_cmd <= 1'b1;
      run_for(16'h8042, 64, q);
      chk_rng("external edges", 29, 35, q);
      run_cmd <= 1'b0;
      idle <= 1'b1;
      run_for(16'ha000, 64, q);
      chk_val("idle stopped count", 32'h0, q);
      run_for(16'h8000, 64, q);
      chk_rng("idle running count", 60, 68, q);
      idle <= 1'b0;
   endtask : t_source

   // The upper lane on its own: gate held shut, then its external pin at 1:1.
   task automatic t_upper;
      logic [31:0] q;
      wr(OFS_CNT_HI, 16'h0000);
      wr(OFS_HI_CTL, 16'h8040);
      repeat (64) @(posedge clk);
      rd(OFS_CNT_HI, q);
      chk_val("upper gated count", 32'h0, q);
      run_cmd <= 1'b1;
      wr(OFS_HI_CTL, 16'h8002);
      repeat (64) @(posedge clk);
      wr(OFS_HI_CTL, 16'h0000);
      rd(OFS_CNT_HI, q);
      chk_rng("upper external edges", 29, 35, q);
      run_cmd <= 1'b0;
      wr(OFS_CNT_HI, 16'h0000);
   endtask : t_upper

   task automatic t_match16;
      logic [31:0] q;
      adc_seen = 1'b0;
      wr(OFS_PER_LO, 16'h0002);
      wr(OFS_PER_HI, 16'h0003);
      wr(OFS_CNT_LO, 16'h0000);
      wr(OFS_IRQ_EN, 16'h0003);
      wr(OFS_HI_CTL, 16'h8000);
      wr(OFS_LO_CTL, 16'h8000);
      repeat (20) @(posedge clk);
      wr(OFS_LO_CTL, 16'h0000);
      wr(OFS_HI_CTL, 16'h0000);
      rd(OFS_CNT_LO, q);
      chk_rng("count after wrap", 0, 2, q);
      rd(OFS_IRQ_STAT, q);
      chk_val("both lanes matched", 32'h3, q);
      chk_val("upper lane trigger", 32'h1, {31'h0, adc_seen});
      chk_val("irq enabled", 32'h1, {31'h0, irq});
      wr(OFS_IRQ_EN, 16'h0000);
      @(posedge clk);
      chk_val("irq masked", 32'h0, {31'h0, irq});
      wr(OFS_IRQ_CLR, 16'h0003);
      rd(OFS_IRQ_STAT, q);
      chk_val("status cleared", 32'h0, q);
   endtask : t_match16

   task automatic t_pair32;
      logic [31:0] q;
      adc_seen = 1'b0;
      wr(OFS_LO_CTL, 16'h0008);
      wr(OFS_HI_CTL, 16'h8030);
      wr(OFS_CNT_HI, 16'h0000);
      wr(OFS_CNT_LO, 16'hfff0);
      wr(OFS_PER_HI, 16'h0001);
      wr(OFS_PER_LO, 16'h0005);
      wr(OFS_IRQ_EN, 16'h0002);
      wr(OFS_LO_CTL, 16'h8008);
      for (int i = 0; i < 100 && irq !== 1'b1; i++) begin
         @(posedge clk);
      end
      chk_val("paired match irq", 32'h1, {31'h0, irq});
      wr(OFS_LO_CTL, 16'h0008);
      rd(OFS_IRQ_STAT, q);
      chk_val("paired flag", 32'h2, q);
      chk_val("paired trigger", 32'h1, {31'h0, adc_seen});
      rd(OFS_CNT_LO, q);
      chk_rng("paired low after wrap", 0, 8, q);
      rd(OFS_HOLD, q);
      chk_val("paired high word", 32'h0, q);
   endtask : t_pair32

   initial begin
      clk = 1'b0;
      rst_b = 1'b0;
      {cyc, stb, we, idle, run_cmd, g_lo, g_hi, adc_seen} = 8'h00;
      adr = 8'h00;
      dat = 32'h0;
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      t_regs();
      t_presc();
      t_ctl_write();
      t_source();
      t_upper();
      t_match16();
      t_pair32();
      close_out();
   end
endmodule : test_paired_16_32_bit_timer

`default_nettype wire
